// File: shared/dsp_pkg.sv
package dsp_pkg;
  // ==========================================================
  // Widths
  localparam int SUM_W = 32;  // Primary and backup sum registers
  localparam int DATA_W = 16;  // Data memory and port data
  localparam int ADDR_W = 16;  // Data memory address
  localparam int PORT_W = 3;  // Port select on the low address lines
  localparam int IRQ_N = 16;  // Maskable interrupt sources
  localparam int REG_AW = 4;  // Register bus byte address
  localparam int OP_W = 4;  // Command code width
  localparam int RAM_AW = 10;  // On-chip RAM array index

  // ==========================================================
  // Command codes
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_KEEP_LARGER = 4'h1;
  localparam logic [3:0] OP_KEEP_SMALLER = 4'h2;
  localparam logic [3:0] OP_IRQ_OFF = 4'h3;
  localparam logic [3:0] OP_IRQ_ON = 4'h4;
  localparam logic [3:0] OP_SHIFT_COPY = 4'h5;
  localparam logic [3:0] OP_SWAP_SUMS = 4'h6;
  localparam logic [3:0] OP_SERIAL_SIZE = 4'h7;
  localparam logic [3:0] OP_IDLE = 4'h8;
  localparam logic [3:0] OP_DEEP_SLEEP = 4'h9;
  localparam logic [3:0] OP_PORT_IN = 4'ha;

  // ==========================================================
  // Register map and control field positions
  localparam logic [3:0] REG_PRIMARY = 4'h0;
  localparam logic [3:0] REG_BACKUP = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_ENABLE = 4'hc;
  localparam int ST_CARRY = 0;
  localparam int ST_BLOCK = 1;
  localparam int ST_WORDSEL = 2;
  localparam int ST_B0_DATA = 3;
  localparam int ST_COPY_ERR = 4;
  localparam int ST_IDLE = 5;
  localparam int ST_SLEEP = 6;

  // ==========================================================
  // Reset values
  localparam logic RST_BLOCK = 1'b1;  // Interrupts blocked out of reset
  localparam logic RST_WORDSEL = 1'b0;  // 16-bit serial words
  localparam logic RST_B0_DATA = 1'b1;  // Block zero mapped as data

  // ==========================================================
  // On-chip RAM block windows
  localparam logic [15:0] B0_LO = 16'h0200;
  localparam logic [15:0] B0_HI = 16'h02ff;
  localparam logic [15:0] B1_LO = 16'h0300;
  localparam logic [15:0] B1_HI = 16'h03ff;
  localparam logic [15:0] B2_LO = 16'h0060;
  localparam logic [15:0] B2_HI = 16'h007f;

  // Address lies in a block that is data memory right now
  function automatic logic in_onchip_ram(input logic [15:0] a, input logic b0_data);
    in_onchip_ram = (b0_data && a >= B0_LO && a <= B0_HI) ||
                    (a >= B1_LO && a <= B1_HI) || (a >= B2_LO && a <= B2_HI);
  endfunction : in_onchip_ram
endpackage : dsp_pkg

// File: src/onchip_ram.sv
`timescale 1ns/1ps
module onchip_ram (
  input wire logic sys_clk,
  input wire logic b0_data,
  input wire logic rd_en,
  input wire logic [dsp_pkg::ADDR_W-1:0] rd_addr,
  output logic [dsp_pkg::DATA_W-1:0] rd_data,
  input wire logic wr_en,
  input wire logic [dsp_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [dsp_pkg::DATA_W-1:0] wr_data
);
  import dsp_pkg::*;

  // ==========================================================
  // Storage
  // Blocks share one array; their windows never overlap in the low index bits
  logic [DATA_W-1:0] mem [0:(1<<RAM_AW)-1];

  // Synchronous read; outside the blocks reads as zero
  always_ff @(posedge sys_clk) begin
    if (rd_en) begin
      if (in_onchip_ram(rd_addr, b0_data)) begin
        rd_data <= mem[rd_addr[RAM_AW-1:0]];
      end else begin
        rd_data <= '0;
      end
    end
  end

  // Writes outside the blocks are dropped, external memory is not here
  always_ff @(posedge sys_clk) begin
    if (wr_en && in_onchip_ram(wr_addr, b0_data)) begin
      mem[wr_addr[RAM_AW-1:0]] <= wr_data;
    end
  end
endmodule : onchip_ram

// File: src/dsp_cmd_core.sv
`timescale 1ns/1ps
// Function
// - Keep-larger writes signed maximum into both
// - Keep-larger sets carry when primary >= backup
// - Keep-smaller writes signed minimum into both
// - Keep-smaller clears carry when primary < backup
// - Irq-off sets global block, blocks at once
// - Irq-off spares reset irq and enables
// - Irq-on clears global block, accepts at once
// - Shift-copy writes word to next address
// - Shift-copy acts only inside on-chip blocks
// - Swap-sums exchanges both registers at once
// - Serial-size loads word-length select bit
// - Idle halts until reset or interrupt
// - Deep sleep gates clock until unmasked irq
// - Port-input stores 16-bit port word
// - Two-cycle port read with low strobe
// - Later port read uses select, strobes, ready
module dsp_cmd_core #(
  parameter bit LEGACY_PORT = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [dsp_pkg::REG_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic cmd_valid,
  input wire logic [dsp_pkg::OP_W-1:0] cmd_op,
  input wire logic [dsp_pkg::ADDR_W-1:0] cmd_dma,
  input wire logic [dsp_pkg::PORT_W-1:0] cmd_port,
  input wire logic cmd_imm,
  output logic cmd_ready,
  output logic cmd_done,
  input wire logic [dsp_pkg::IRQ_N-1:0] irq_req,
  input wire logic reset_vector_irq,
  output logic irq_accept,
  output logic reset_irq_accept,
  output logic func_clk_en,
  output logic word_len_sel,
  output logic [dsp_pkg::ADDR_W-1:0] ext_addr,
  input wire logic [dsp_pkg::DATA_W-1:0] ext_data_in,
  input wire logic ext_ready,
  output logic port_read_strobe_n,
  output logic io_space_select_n,
  output logic bus_cycle_strobe_n,
  output logic read_strobe_n
);
  import dsp_pkg::*;

  // ==========================================================
  // State
  typedef enum {S_RUN, S_COPY, S_PORT_A, S_PORT_B, S_PORT_STORE, S_IDLE, S_SLEEP} state_e;
  state_e state_r;  // Sequencer state
  state_e state_nxt;  // Next sequencer state

  logic signed [SUM_W-1:0] primary_sum_register_r;  // Working sum
  logic signed [SUM_W-1:0] backup_sum_register_r;  // Buffered sum
  logic carry_r;  // Carry bit
  logic global_irq_block_r;  // Blocks maskable interrupts when set
  logic [IRQ_N-1:0] per_source_enable_set_r;  // Source enables
  logic b0_data_r;  // Block zero mapped as data memory
  logic copy_err_r;  // Sticky: shift-copy left the blocks
  logic [ADDR_W-1:0] dma_r;  // Latched data memory address
  logic [DATA_W-1:0] port_data_r;  // Word captured from the port
  logic [DATA_W-1:0] ram_rd_data;  // RAM read result
  logic cmd_fire;  // Command taken this cycle
  logic maskable_pend;  // Enabled source is requesting
  logic copy_ok;  // Source and target both inside blocks
  logic ram_wr_en;  // RAM write strobe
  logic [ADDR_W-1:0] ram_wr_addr;  // RAM write address
  logic [DATA_W-1:0] ram_wr_data;  // RAM write data
  logic [7:0] status_word;  // Status register image

  assign cmd_ready = (state_r == S_RUN);
  assign cmd_fire = cmd_valid && cmd_ready;
  assign maskable_pend = |(irq_req & per_source_enable_set_r);
  assign copy_ok = in_onchip_ram(dma_r, b0_data_r) &&
                   in_onchip_ram(dma_r + 16'h0001, b0_data_r);

  // ==========================================================
  // Sequencer
  // Next state; multi-cycle commands leave S_RUN and hold off new ones
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_RUN: begin
        if (cmd_fire) begin
          case (cmd_op)
            OP_SHIFT_COPY: state_nxt = S_COPY;
            OP_PORT_IN: state_nxt = S_PORT_A;
            OP_IDLE: state_nxt = S_IDLE;
            OP_DEEP_SLEEP: state_nxt = S_SLEEP;
            default: state_nxt = S_RUN;
          endcase
        end
      end
      S_COPY: state_nxt = S_RUN;
      S_PORT_A: begin
        // Legacy strobe is a fixed two cycles; later bus waits on ready
        if (LEGACY_PORT) begin
          state_nxt = S_PORT_B;
        end else if (ext_ready) begin
          state_nxt = S_PORT_STORE;
        end
      end
      S_PORT_B: state_nxt = S_PORT_STORE;
      S_PORT_STORE: state_nxt = S_RUN;
      S_IDLE: begin
        // Any enabled request wakes idle, even while globally blocked
        if (maskable_pend || reset_vector_irq) begin
          state_nxt = S_RUN;
        end
      end
      S_SLEEP: begin
        // Only an unmasked request may restart the gated clock
        if ((maskable_pend && !global_irq_block_r) || reset_vector_irq) begin
          state_nxt = S_RUN;
        end
      end
      default: state_nxt = S_RUN;
    endcase
  end

  // State register; reset always returns to execution
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= S_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Completion pulse, one cycle after the last cycle of a command
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cmd_done <= 1'b0;
    end else begin
      cmd_done <= (cmd_fire && cmd_op != OP_SHIFT_COPY && cmd_op != OP_PORT_IN &&
                   cmd_op != OP_IDLE && cmd_op != OP_DEEP_SLEEP) ||
                  state_r == S_COPY || state_r == S_PORT_STORE ||
                  ((state_r == S_IDLE || state_r == S_SLEEP) && state_nxt == S_RUN);
    end
  end

  // ==========================================================
  // Sum registers and carry
  // Commands win over a bus write in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      primary_sum_register_r <= '0;
      backup_sum_register_r <= '0;
    end else if (cmd_fire && cmd_op == OP_KEEP_LARGER) begin
      if (primary_sum_register_r >= backup_sum_register_r) begin
        backup_sum_register_r <= primary_sum_register_r;
      end else begin
        primary_sum_register_r <= backup_sum_register_r;
      end
    end else if (cmd_fire && cmd_op == OP_KEEP_SMALLER) begin
      if (primary_sum_register_r < backup_sum_register_r) begin
        backup_sum_register_r <= primary_sum_register_r;
      end else begin
        primary_sum_register_r <= backup_sum_register_r;
      end
    end else if (cmd_fire && cmd_op == OP_SWAP_SUMS) begin
      primary_sum_register_r <= backup_sum_register_r;
      backup_sum_register_r <= primary_sum_register_r;
    end else if (reg_wr && reg_addr == REG_PRIMARY) begin
      primary_sum_register_r <= reg_wdata;
    end else if (reg_wr && reg_addr == REG_BACKUP) begin
      backup_sum_register_r <= reg_wdata;
    end
  end

  // Both compares reduce to the same carry: set unless primary is below
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      carry_r <= 1'b0;
    end else if (cmd_fire && cmd_op == OP_KEEP_LARGER) begin
      carry_r <= (primary_sum_register_r >= backup_sum_register_r);
    end else if (cmd_fire && cmd_op == OP_KEEP_SMALLER) begin
      carry_r <= !(primary_sum_register_r < backup_sum_register_r);
    end
  end

  // ==========================================================
  // Interrupt masking
  // Only the global block changes; enables and reset request are untouched
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      global_irq_block_r <= RST_BLOCK;
    end else if (cmd_fire && cmd_op == OP_IRQ_OFF) begin
      global_irq_block_r <= 1'b1;
    end else if (cmd_fire && cmd_op == OP_IRQ_ON) begin
      global_irq_block_r <= 1'b0;
    end
  end

  // Source enables are software state, written over the bus only
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      per_source_enable_set_r <= '0;
    end else if (reg_wr && reg_addr == REG_ENABLE) begin
      per_source_enable_set_r <= reg_wdata[IRQ_N-1:0];
    end
  end

  // Acceptance only where the core can branch: running or waiting
  assign irq_accept = maskable_pend && !global_irq_block_r &&
                      (state_r == S_RUN || state_r == S_IDLE || state_r == S_SLEEP);
  assign reset_irq_accept = reset_vector_irq;
  assign func_clk_en = (state_r != S_SLEEP);

  // ==========================================================
  // Serial word size and memory map
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      word_len_sel <= RST_WORDSEL;
    end else if (cmd_fire && cmd_op == OP_SERIAL_SIZE) begin
      word_len_sel <= cmd_imm;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      b0_data_r <= RST_B0_DATA;
    end else if (reg_wr && reg_addr == REG_STATUS) begin
      b0_data_r <= reg_wdata[ST_B0_DATA];
    end
  end

  // Sticky range fault; a new fault wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      copy_err_r <= 1'b0;
    end else if (state_r == S_COPY && !copy_ok) begin
      copy_err_r <= 1'b1;
    end else if (reg_wr && reg_addr == REG_STATUS && reg_wdata[ST_COPY_ERR]) begin
      copy_err_r <= 1'b0;
    end
  end

  // ==========================================================
  // Data memory path
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dma_r <= '0;
    end else if (cmd_fire) begin
      dma_r <= cmd_dma;
    end
  end

  // Copy writes the read word one address up; port-in writes the port word
  always_comb begin
    ram_wr_en = 1'b0;
    ram_wr_addr = dma_r;
    ram_wr_data = port_data_r;
    if (state_r == S_COPY) begin
      ram_wr_en = copy_ok;
      ram_wr_addr = dma_r + 16'h0001;
      ram_wr_data = ram_rd_data;
    end else if (state_r == S_PORT_STORE) begin
      ram_wr_en = 1'b1;
    end
  end

  onchip_ram u_ram (
    .sys_clk(sys_clk),
    .b0_data(b0_data_r),
    .rd_en(cmd_fire && cmd_op == OP_SHIFT_COPY),
    .rd_addr(cmd_dma),
    .rd_data(ram_rd_data),
    .wr_en(ram_wr_en),
    .wr_addr(ram_wr_addr),
    .wr_data(ram_wr_data)
  );

  // ==========================================================
  // Port read bus
  // Port number rides on the low address lines for the whole access
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ext_addr <= '0;
    end else if (cmd_fire && cmd_op == OP_PORT_IN) begin
      ext_addr <= {13'h0000, cmd_port};
    end
  end

  // Capture the 16-bit word at the end of the strobe
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      port_data_r <= '0;
    end else if ((LEGACY_PORT && state_r == S_PORT_B) ||
                 (!LEGACY_PORT && state_r == S_PORT_A && ext_ready)) begin
      port_data_r <= ext_data_in;
    end
  end

  assign port_read_strobe_n = !(LEGACY_PORT && (state_r == S_PORT_A || state_r == S_PORT_B));
  assign io_space_select_n = !(!LEGACY_PORT && state_r == S_PORT_A);
  assign bus_cycle_strobe_n = !(!LEGACY_PORT && state_r == S_PORT_A);
  assign read_strobe_n = !(!LEGACY_PORT && state_r == S_PORT_A);

  // ==========================================================
  // Register bus
  always_comb begin
    status_word = 8'h00;
    status_word[ST_CARRY] = carry_r;
    status_word[ST_BLOCK] = global_irq_block_r;
    status_word[ST_WORDSEL] = word_len_sel;
    status_word[ST_B0_DATA] = b0_data_r;
    status_word[ST_COPY_ERR] = copy_err_r;
    status_word[ST_IDLE] = (state_r == S_IDLE);
    status_word[ST_SLEEP] = (state_r == S_SLEEP);
  end

  // Read data stand only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (!reg_rd) begin
      reg_rdata <= '0;
    end else if (reg_addr == REG_PRIMARY) begin
      reg_rdata <= primary_sum_register_r;
    end else if (reg_addr == REG_BACKUP) begin
      reg_rdata <= backup_sum_register_r;
    end else if (reg_addr == REG_STATUS) begin
      reg_rdata <= {24'h000000, status_word};
    end else if (reg_addr == REG_ENABLE) begin
      reg_rdata <= {16'h0000, per_source_enable_set_r};
    end else begin
      reg_rdata <= '0;
    end
  end

  // ==========================================================
  // Checks
  property p_larger;
    @(posedge sys_clk) disable iff (!rst_n)
    cmd_fire && cmd_op == OP_KEEP_LARGER |=> primary_sum_register_r == backup_sum_register_r &&
      primary_sum_register_r >= $past(primary_sum_register_r) &&
      primary_sum_register_r >= $past(backup_sum_register_r);
  endproperty
  a_larger: assert property (p_larger) else $error("keep-larger result wrong");

  property p_carry_larger;
    @(posedge sys_clk) disable iff (!rst_n)
    cmd_fire && cmd_op == OP_KEEP_LARGER |=>
      carry_r == ($past(primary_sum_register_r) >= $past(backup_sum_register_r));
  endproperty
  a_carry_larger: assert property (p_carry_larger) else $error("keep-larger carry wrong");

  property p_smaller;
    @(posedge sys_clk) disable iff (!rst_n)
    cmd_fire && cmd_op == OP_KEEP_SMALLER |=> primary_sum_register_r == backup_sum_register_r &&
      primary_sum_register_r <= $past(primary_sum_register_r) &&
      primary_sum_register_r <= $past(backup_sum_register_r);
  endproperty
  a_smaller: assert property (p_smaller) else $error("keep-smaller result wrong");

  property p_carry_smaller;
    @(posedge sys_clk) disable iff (!rst_n)
    cmd_fire && cmd_op == OP_KEEP_SMALLER |=>
      carry_r == !($past(primary_sum_register_r) < $past(backup_sum_register_r));
  endproperty
  a_carry_smaller: assert property (p_carry_smaller) else $error("keep-smaller carry wrong");

  property p_irq_off;
    @(posedge sys_clk) disable iff (!rst_n)
    cmd_fire && cmd_op == OP_IRQ_OFF |=> global_irq_block_r && !irq_accept &&
      per_source_enable_set_r == $past(per_source_enable_set_r);
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq-off did not block");

  property p_irq_on;
    @(posedge sys_clk) disable iff (!rst_n)
    cmd_fire && cmd_op == OP_IRQ_ON ##1 (state_r == S_RUN && maskable_pend) |-> irq_accept;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq-on did not accept");

  property p_swap;
    @(posedge sys_clk) disable iff (!rst_n)
    cmd_fire && cmd_op == OP_SWAP_SUMS |=> primary_sum_register_r == $past(backup_sum_register_r)
      && backup_sum_register_r == $past(primary_sum_register_r);
  endproperty
  a_swap: assert property (p_swap) else $error("swap-sums wrong");

  property p_word;
    @(posedge sys_clk) disable iff (!rst_n)
    cmd_fire && cmd_op == OP_SERIAL_SIZE |=> word_len_sel == $past(cmd_imm);
  endproperty
  a_word: assert property (p_word) else $error("word-length select wrong");

  property p_sleep;
    @(posedge sys_clk) disable iff (!rst_n)
    cmd_fire && cmd_op == OP_DEEP_SLEEP |=> !func_clk_en && !cmd_ready;
  endproperty
  a_sleep: assert property (p_sleep) else $error("deep sleep left clock on");

  property p_idle;
    @(posedge sys_clk) disable iff (!rst_n)
    state_r == S_IDLE && !maskable_pend && !reset_vector_irq |=> state_r == S_IDLE;
  endproperty
  a_idle: assert property (p_idle) else $error("idle left without wake");

  property p_copy;
    @(posedge sys_clk) disable iff (!rst_n)
    state_r == S_COPY |-> ram_wr_en == copy_ok && ram_wr_addr == dma_r + 16'h0001;
  endproperty
  a_copy: assert property (p_copy) else $error("shift-copy target wrong");

  property p_port;
    @(posedge sys_clk) disable iff (!rst_n)
    cmd_fire && cmd_op == OP_PORT_IN |=> (!port_read_strobe_n == LEGACY_PORT) &&
      (!io_space_select_n == !LEGACY_PORT) && (!read_strobe_n == !LEGACY_PORT) &&
      ext_addr[2:0] == $past(cmd_port) ##1 (!port_read_strobe_n == LEGACY_PORT);
  endproperty
  a_port: assert property (p_port) else $error("port read strobe wrong");
endmodule : dsp_cmd_core

// File: tb/io_peripheral.sv
`timescale 1ns/1ps
// ==========================================================
// Port peripheral: answers a select, strobe and read cycle after wait_cycles
// It also serves the two-cycle strobe bus, holding its word while that strobe is low
module io_peripheral (
  input wire logic sys_clk,
  input wire logic [15:0] ext_addr,
  input wire logic io_space_select_n,
  input wire logic bus_cycle_strobe_n,
  input wire logic read_strobe_n,
  input wire logic [3:0] wait_cycles,
  output logic [15:0] ext_data_in,
  output logic ext_ready,
  input wire logic [15:0] legacy_addr,
  input wire logic legacy_strobe_n,
  output logic [15:0] legacy_data
);
  logic [3:0] cnt_r;  // Cycles since the cycle began
  logic sel;  // Port read in progress
  logic hit;  // Answer cycle
  assign sel = !io_space_select_n && !bus_cycle_strobe_n && !read_strobe_n;
  assign hit = sel && cnt_r == wait_cycles;
  // Strobed word only while the strobe is low; the inverse otherwise
  assign legacy_data = legacy_strobe_n ? ~{13'h1a5c, legacy_addr[2:0]} :
                       {13'h1a5c, legacy_addr[2:0]};
  initial begin
    cnt_r = 4'h0;
    ext_ready = 1'b0;
    ext_data_in = 16'h0000;
  end
  // Data stands only with ready; otherwise it inverts every cycle, so a stale word matches only on alternate cycles
  always @(posedge sys_clk) begin
    cnt_r <= sel ? cnt_r + 4'h1 : 4'h0;
    ext_ready <= hit;
    ext_data_in <= hit ? {13'h1a5c, ext_addr[2:0]} : ~ext_data_in;
  end
endmodule : io_peripheral

// File: tb/tb.sv
`timescale 1ns/1ps
// ==========================================================
// Command core bench
module tb;
  import dsp_pkg::*;
  logic sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, cmd_valid = 0, cmd_imm = 0;
  logic reset_vector_irq = 0;
  logic [3:0] reg_addr = 0, cmd_op = 0, wait_cycles = 0;
  logic [31:0] reg_wdata = 0, v, reg_rdata;
  logic [15:0] cmd_dma = 0, irq_req = 0, ext_addr, ext_data_in;
  logic [2:0] cmd_port = 0;
  logic cmd_ready, cmd_done, irq_accept, reset_irq_accept, func_clk_en, word_len_sel;
  logic ext_ready, port_read_strobe_n, io_space_select_n, bus_cycle_strobe_n, read_strobe_n;
  logic [15:0] legacy_addr, legacy_data;
  logic legacy_strobe_n;
  int miscompares = 0, compares = 0;
  always #2.5 sys_clk = ~sys_clk;
  dsp_cmd_core #(.LEGACY_PORT(1'b0)) dut (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .cmd_valid, .cmd_op, .cmd_dma, .cmd_port, .cmd_imm, .cmd_ready,
    .cmd_done, .irq_req, .reset_vector_irq, .irq_accept, .reset_irq_accept, .func_clk_en,
    .word_len_sel, .ext_addr, .ext_data_in, .ext_ready, .port_read_strobe_n,
    .io_space_select_n, .bus_cycle_strobe_n, .read_strobe_n);
  // Two-cycle strobe variant follows the same commands beside the ready variant
  dsp_cmd_core #(.LEGACY_PORT(1'b1)) dut_legacy (.sys_clk, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata(), .cmd_valid, .cmd_op, .cmd_dma, .cmd_port, .cmd_imm,
    .cmd_ready(), .cmd_done(), .irq_req, .reset_vector_irq, .irq_accept(),
    .reset_irq_accept(), .func_clk_en(), .word_len_sel(), .ext_addr(legacy_addr),
    .ext_data_in(legacy_data), .ext_ready(1'b0), .port_read_strobe_n(legacy_strobe_n),
    .io_space_select_n(), .bus_cycle_strobe_n(), .read_strobe_n());
  io_peripheral per (.sys_clk, .ext_addr, .io_space_select_n, .bus_cycle_strobe_n,
    .read_strobe_n, .wait_cycles, .ext_data_in, .ext_ready, .legacy_addr,
    .legacy_strobe_n, .legacy_data);
  // ==========================================================
  // Shared tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // Bounded wait for the completion pulse, looked at mid-cycle
  task wait_done;
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (cmd_done !== 1'b1 && n < 60);
    chk(cmd_done, 1);
  endtask : wait_done
  task cmd(input logic [3:0] op, input logic [15:0] a, input logic [2:0] p, input logic i,
           input bit wt);
    @(posedge sys_clk);
    cmd_op <= op;
    cmd_dma <= a;
    cmd_port <= p;
    cmd_imm <= i;
    cmd_valid <= 1'b1;
    do @(negedge sys_clk); while (cmd_ready !== 1'b1);
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    if (wt) wait_done();
  endtask : cmd
  // ==========================================================
  // Scenarios
  task t_sums;
    wr(REG_PRIMARY, 32'hffff_fff0);
    wr(REG_BACKUP, 32'h0000_0010);
    cmd(OP_KEEP_LARGER, 0, 0, 0, 1);
    rd(REG_PRIMARY, v); chk(v, 32'h10);
    rd(REG_BACKUP, v); chk(v, 32'h10);
    rd(REG_STATUS, v); chk(v[ST_CARRY], 0);
    cmd(OP_KEEP_LARGER, 0, 0, 0, 1);
    rd(REG_STATUS, v); chk(v[ST_CARRY], 1);
    wr(REG_PRIMARY, 32'h0000_0005);
    wr(REG_BACKUP, 32'h8000_0000);
    cmd(OP_KEEP_SMALLER, 0, 0, 0, 1);
    rd(REG_PRIMARY, v); chk(v, 32'h8000_0000);
    rd(REG_STATUS, v); chk(v[ST_CARRY], 1);
    wr(REG_BACKUP, 32'h7fff_ffff);
    cmd(OP_KEEP_SMALLER, 0, 0, 0, 1);
    rd(REG_BACKUP, v); chk(v, 32'h8000_0000);
    rd(REG_STATUS, v); chk(v[ST_CARRY], 0);
    wr(REG_BACKUP, 32'h1234_5678);
    cmd(OP_SWAP_SUMS, 0, 0, 0, 1);
    rd(REG_PRIMARY, v); chk(v, 32'h1234_5678);
    rd(REG_BACKUP, v); chk(v, 32'h8000_0000);
  endtask : t_sums
  task t_irq;
    wr(REG_ENABLE, 32'h4);
    irq_req <= 16'h0004;
    cmd(OP_IRQ_ON, 0, 0, 0, 1);
    chk(irq_accept, 1);
    cmd(OP_IRQ_OFF, 0, 0, 0, 1);
    chk(irq_accept, 0);
    @(posedge sys_clk) reset_vector_irq <= 1'b1;
    @(negedge sys_clk) chk(reset_irq_accept, 1);
    @(posedge sys_clk) reset_vector_irq <= 1'b0;
    rd(REG_ENABLE, v); chk(v, 32'h4);
    for (int i = 1; i >= 0; i--) begin
      cmd(OP_SERIAL_SIZE, 0, 0, i[0], 1);
      chk(word_len_sel, i[0]);
    end
  endtask : t_irq
  // Two answer speeds, then the stored word is copied within its block
  task t_port;
    for (int w = 0; w < 6; w += 5) begin
      wait_cycles <= w[3:0];
      cmd(OP_PORT_IN, B2_LO, 3'h5, 0, 0);
      @(negedge sys_clk);
      chk({io_space_select_n, bus_cycle_strobe_n, read_strobe_n}, 0);
      chk(ext_addr[2:0], 3'h5);
      chk({port_read_strobe_n, legacy_strobe_n}, 2'b10);
      chk(legacy_addr[2:0], 3'h5);
      wait_done();
      chk(dut.u_ram.mem[B2_LO[9:0]], {13'h1a5c, 3'h5});
      chk(dut_legacy.u_ram.mem[B2_LO[9:0]], {13'h1a5c, 3'h5});
      chk(legacy_strobe_n, 1);
    end
    cmd(OP_SHIFT_COPY, B2_LO, 0, 0, 1);
    rd(REG_STATUS, v); chk(v[ST_COPY_ERR], 0);
    chk(dut.u_ram.mem[B2_LO[9:0] + 10'h001], {13'h1a5c, 3'h5});
    cmd(OP_SHIFT_COPY, 16'h0100, 0, 0, 1);
    rd(REG_STATUS, v); chk(v[ST_COPY_ERR], 1);
    wr(REG_STATUS, 32'h10);
    cmd(OP_SHIFT_COPY, B0_LO, 0, 0, 1);
    rd(REG_STATUS, v); chk(v[4:3], 2'b10);
    wr(REG_STATUS, 32'h18);
  endtask : t_port
  // Idle wakes on an enabled request even while blocked; deep sleep does not
  task t_sleep;
    irq_req <= 16'h0000;
    cmd(OP_IDLE, 0, 0, 0, 0);
    rd(REG_STATUS, v); chk(v[ST_IDLE], 1);
    chk(cmd_ready, 0);
    @(posedge sys_clk) irq_req <= 16'h0004;
    wait_done();
    cmd(OP_DEEP_SLEEP, 0, 0, 0, 0);
    repeat (6) @(negedge sys_clk);
    chk({func_clk_en, cmd_ready}, 0);
    @(posedge sys_clk) reset_vector_irq <= 1'b1;
    wait_done();
    chk(func_clk_en, 1);
    @(posedge sys_clk) reset_vector_irq <= 1'b0;
  endtask : t_sleep
  // ==========================================================
  // Verdict and run control
  task give_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_sums();
    t_irq();
    t_port();
    t_sleep();
    give_verdict();
  end
  // The sequence needs well under a thousand cycles
  initial begin
    #100000;
    miscompares++;
    give_verdict();
  end
endmodule : tb
